//--- src/duart_pins_pkg.sv
// Contract
// (R1) on interrupt acknowledge, drive vector and transfer ack only if irq pending
// (R2) system supplies a continuous reference clock near 3.6864 MHz
// (R3) receivers take lsb first; high line is mark, low is space
// (R4) transmitters send lsb first; output held mark when disabled, idle, loopback (a frame under way when tx_enable drops is still sent in full)
// (R5) out port bit 0/1 selectable as general output or channel a/b rts_n
// (R6) rts_n may auto-deassert on receiver condition or transmitter completion
// (R7) out port bit 2 selectable as channel a tx clock at 1x or 16x
// (R8) out port bit 4 selectable as open-drain active-low rx ready or fifo full
// (R9) multi-function bits default to general output until configured otherwise
package duart_pins_pkg;
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned REF_CLK_HZ     = 3_686_400;
  localparam int unsigned DATA_BITS      = 8;
  localparam int unsigned OVERSAMPLE     = 16;
  localparam int unsigned BAUD_DIV_W     = 16;
  localparam logic [15:0] BAUD_DIV_RST   = 16'h0041;
  localparam logic [7:0]  VECTOR_RST     = 8'h0F;
  localparam int unsigned FIFO_DEPTH     = 4;
  localparam int unsigned BIT_RTS_A      = 0;
  localparam int unsigned BIT_RTS_B      = 1;
  localparam int unsigned BIT_TXCLK_A    = 2;
  localparam int unsigned BIT_RXRDY_A    = 4;
  localparam logic [7:0]  OUT_PORT_RST   = 8'h00;
  typedef enum logic {TXCLK_1X, TXCLK_16X} txclk_sel_e;
  typedef enum logic {RXIND_READY, RXIND_FULL} rxind_sel_e;
endpackage

//--- src/uart_chan.sv
`timescale 1ns/1ps
`default_nettype none
module uart_chan
  import duart_pins_pkg::*;
(
  // clock
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  // config
  input  wire logic [BAUD_DIV_W-1:0]   baud_div,
  input  wire logic                    tx_enable,
  input  wire logic                    rx_enable,
  input  wire logic                    loopback,
  // line
  input  wire logic                    serial_in_sync,
  output logic                         serial_out,
  output logic                         tick16,
  output logic                         tick1,
  // tx user
  input  wire logic                    tx_valid,
  input  wire logic [DATA_BITS-1:0]    tx_data,
  output logic                         tx_ready,
  output logic                         tx_done,
  // rx user
  output logic                         rx_valid,
  output logic [DATA_BITS-1:0]         rx_data,
  input  wire logic                    rx_take,
  output logic [2:0]                   rx_count
);
  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} st_e;
  logic [BAUD_DIV_W-1:0] div_r;
  logic [3:0]            ph_r;
  st_e                   tst_r, rst_r;
  logic [3:0]            tph_r, rph_r;
  logic [2:0]            tbit_r, rbit_r;
  logic [DATA_BITS-1:0]  tsh_r, rsh_r;
  logic [DATA_BITS-1:0]  fifo_r [FIFO_DEPTH];
  logic [1:0]            wp_r, rp_r;
  logic                  rx_line;
  logic                  push;

  ////////////////////////////////////////////////////////////////////////////
  // baud generator
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_r <= '0;
      ph_r  <= '0;
    end else if (clk_en) begin
      if (div_r >= baud_div - 1'b1) begin
        div_r <= '0;
        ph_r  <= ph_r + 1'b1;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end
  assign tick16 = clk_en && (div_r >= baud_div - 1'b1);
  assign tick1  = tick16 && (ph_r == 4'hF);

  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  assign tx_ready = tx_enable && (tst_r == S_IDLE);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tst_r      <= S_IDLE;
      tph_r      <= '0;
      tbit_r     <= '0;
      tsh_r      <= '0;
      serial_out <= 1'b1;
      tx_done    <= 1'b0;
    end else if (clk_en) begin
      tx_done <= 1'b0;
      unique case (tst_r)
        S_IDLE: begin
          serial_out <= 1'b1; // R4
          if (tx_valid && tx_ready) begin
            tsh_r <= tx_data;
            tph_r <= '0;
            tst_r <= S_START;
          end
        end
        S_START: begin
          serial_out <= loopback;
          if (tick16) begin
            tph_r <= tph_r + 1'b1;
            if (tph_r == 4'hF) begin
              tbit_r <= '0;
              tst_r  <= S_DATA;
            end
          end
        end
        S_DATA: begin
          serial_out <= tsh_r[0] | loopback; // R4
          if (tick16) begin
            tph_r <= tph_r + 1'b1;
            if (tph_r == 4'hF) begin
              tsh_r  <= tsh_r >> 1; // R4
              tbit_r <= tbit_r + 1'b1;
              if (tbit_r == 3'(DATA_BITS - 1))
                tst_r <= S_STOP;
            end
          end
        end
        S_STOP: begin
          serial_out <= 1'b1;
          if (tick16) begin
            tph_r <= tph_r + 1'b1;
            if (tph_r == 4'hF) begin
              tst_r   <= S_IDLE;
              tx_done <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  assign rx_line = loopback ? (tst_r == S_DATA ? tsh_r[0] : tst_r != S_START)
                            : serial_in_sync;
  assign push = clk_en && tick16 && rst_r == S_STOP && rph_r == 4'hF &&
                rx_line && rx_count != 3'(FIFO_DEPTH);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rst_r  <= S_IDLE;
      rph_r  <= '0;
      rbit_r <= '0;
      rsh_r  <= '0;
    end else if (clk_en && tick16) begin
      unique case (rst_r)
        S_IDLE: begin
          rph_r <= '0;
          if (rx_enable && !rx_line)
            rst_r <= S_START; // R3
        end
        S_START: begin
          rph_r <= rph_r + 1'b1;
          if (rph_r == 4'h7) begin
            rph_r  <= '0;
            rbit_r <= '0;
            rst_r  <= rx_line ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          rph_r <= rph_r + 1'b1;
          if (rph_r == 4'hF) begin
            rsh_r  <= {rx_line, rsh_r[DATA_BITS-1:1]}; // R3
            rbit_r <= rbit_r + 1'b1;
            if (rbit_r == 3'(DATA_BITS - 1))
              rst_r <= S_STOP;
          end
        end
        S_STOP: begin
          rph_r <= rph_r + 1'b1;
          if (rph_r == 4'hF)
            rst_r <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wp_r     <= '0;
      rp_r     <= '0;
      rx_count <= '0;
      rx_data  <= '0;
    end else if (clk_en) begin
      if (push) begin
        fifo_r[wp_r] <= rsh_r;
        wp_r         <= wp_r + 1'b1;
      end
      if (rx_take && rx_valid)
        rp_r <= rp_r + 1'b1;
      rx_count <= rx_count + 3'(push) - 3'(rx_take && rx_valid);
      rx_data  <= fifo_r[(rx_take && rx_valid) ? rp_r + 1'b1 : rp_r];
    end
  end
  assign rx_valid = (rx_count != '0) && (wp_r != rp_r || rx_count[2]);
endmodule
`default_nettype wire

//--- src/duart_pins.sv
`timescale 1ns/1ps
`default_nettype none
module duart_pins
  import duart_pins_pkg::*;
(
  // clock
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  // interrupt acknowledge
  input  wire logic                  irq_ack_in_n,
  input  wire logic                  irq_pending,
  input  wire logic [7:0]            irq_vector,
  output logic [7:0]                 data_out,
  output logic                       data_oe,
  output logic                       transfer_ack_n,
  output logic                       transfer_ack_oe,
  // configuration
  input  wire logic [BAUD_DIV_W-1:0] baud_div_a,
  input  wire logic [BAUD_DIV_W-1:0] baud_div_b,
  input  wire logic [1:0]            tx_enable,
  input  wire logic [1:0]            rx_enable,
  input  wire logic [1:0]            loopback,
  input  wire logic [7:0]            out_port_gp,
  input  wire logic [1:0]            rts_sel,
  input  wire logic [1:0]            rts_auto_rx,
  input  wire logic [1:0]            rts_auto_tx,
  input  wire logic [1:0]            rts_assert,
  input  wire logic                  txclk_sel_en,
  input  wire txclk_sel_e            txclk_rate,
  input  wire logic                  rxind_sel_en,
  input  wire rxind_sel_e            rxind_mode,
  // serial lines
  input  wire logic                  serial_in_ch_a,
  input  wire logic                  serial_in_ch_b,
  output logic                       serial_out_ch_a,
  output logic                       serial_out_ch_b,
  // channel a data
  input  wire logic                  tx_valid_a,
  input  wire logic [7:0]            tx_data_a,
  output logic                       tx_ready_a,
  output logic                       rx_valid_a,
  output logic [7:0]                 rx_data_a,
  input  wire logic                  rx_take_a,
  // channel b data
  input  wire logic                  tx_valid_b,
  input  wire logic [7:0]            tx_data_b,
  output logic                       tx_ready_b,
  output logic                       rx_valid_b,
  output logic [7:0]                 rx_data_b,
  input  wire logic                  rx_take_b,
  // output port
  output logic [7:0]                 out_port,
  output logic                       out_port_bit4_oe
);
  import duart_pins_pkg::*;
  logic [1:0] iack_s_r, rxa_s_r, rxb_s_r;
  logic [1:0] rts_r, txclk_r;
  logic [3:0] txph_r;
  logic [1:0] tick16, tick1, tx_done;
  logic [2:0] cnt_a, cnt_b;
  logic       ack_done_r;
  logic       rx_ind_n;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      iack_s_r <= 2'b11;
      rxa_s_r  <= 2'b11;
      rxb_s_r  <= 2'b11;
    end else if (clk_en) begin
      iack_s_r <= {iack_s_r[0], irq_ack_in_n};
      rxa_s_r  <= {rxa_s_r[0], serial_in_ch_a};
      rxb_s_r  <= {rxb_s_r[0], serial_in_ch_b};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt acknowledge answer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_out        <= '0;
      data_oe         <= 1'b0;
      transfer_ack_n  <= 1'b1;
      transfer_ack_oe <= 1'b0;
      ack_done_r      <= 1'b0;
    end else if (clk_en) begin
      if (!iack_s_r[1] && irq_pending && !ack_done_r) begin
        data_out        <= irq_vector; // R1
        data_oe         <= 1'b1;
        transfer_ack_n  <= 1'b0; // R1
        transfer_ack_oe <= 1'b1;
        ack_done_r      <= 1'b1;
      end else if (iack_s_r[1]) begin
        data_oe         <= 1'b0;
        transfer_ack_n  <= 1'b1;
        transfer_ack_oe <= 1'b0;
        ack_done_r      <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels
  uart_chan u_chan_a (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .clk_en         (clk_en),
    .baud_div       (baud_div_a),
    .tx_enable      (tx_enable[0]),
    .rx_enable      (rx_enable[0]),
    .loopback       (loopback[0]),
    .serial_in_sync (rxa_s_r[1]),
    .serial_out     (serial_out_ch_a),
    .tick16         (tick16[0]),
    .tick1          (tick1[0]),
    .tx_valid       (tx_valid_a),
    .tx_data        (tx_data_a),
    .tx_ready       (tx_ready_a),
    .tx_done        (tx_done[0]),
    .rx_valid       (rx_valid_a),
    .rx_data        (rx_data_a),
    .rx_take        (rx_take_a),
    .rx_count       (cnt_a)
  );
  uart_chan u_chan_b (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .clk_en         (clk_en),
    .baud_div       (baud_div_b),
    .tx_enable      (tx_enable[1]),
    .rx_enable      (rx_enable[1]),
    .loopback       (loopback[1]),
    .serial_in_sync (rxb_s_r[1]),
    .serial_out     (serial_out_ch_b),
    .tick16         (tick16[1]),
    .tick1          (tick1[1]),
    .tx_valid       (tx_valid_b),
    .tx_data        (tx_data_b),
    .tx_ready       (tx_ready_b),
    .tx_done        (tx_done[1]),
    .rx_valid       (rx_valid_b),
    .rx_data        (rx_data_b),
    .rx_take        (rx_take_b),
    .rx_count       (cnt_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request to send, active high internally
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rts_r <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if ((rts_auto_tx[i] && tx_done[i]) ||
            (rts_auto_rx[i] && (i == 0 ? cnt_a : cnt_b) ==
             3'(FIFO_DEPTH)))
          rts_r[i] <= 1'b0; // R6
        else if (rts_assert[i])
          rts_r[i] <= 1'b1;
      end
    end
  end

  // tx clock output for channel a
  // 16x: one pulse per tick; 1x: square wave over sixteen ticks
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      txclk_r <= '0;
      txph_r  <= '0;
    end else if (clk_en) begin
      txclk_r[0] <= tick16[0]; // R7
      if (tick1[0])
        txph_r <= '0;
      else if (tick16[0])
        txph_r <= txph_r + 1'b1;
      txclk_r[1] <= txph_r[3]; // R7
    end
  end

  assign rx_ind_n = (rxind_mode == RXIND_FULL) ?
                    (cnt_a != 3'(FIFO_DEPTH)) : (cnt_a == 3'd0);

  ////////////////////////////////////////////////////////////////////////////
  // output port multiplexing
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out_port         <= ~OUT_PORT_RST;
      out_port_bit4_oe <= 1'b1;
    end else if (clk_en) begin
      out_port <= ~out_port_gp; // R9
      out_port_bit4_oe <= 1'b1;
      if (rts_sel[0])
        out_port[BIT_RTS_A] <= ~rts_r[0]; // R5
      if (rts_sel[1])
        out_port[BIT_RTS_B] <= ~rts_r[1]; // R5
      if (txclk_sel_en)
        out_port[BIT_TXCLK_A] <= (txclk_rate == TXCLK_16X) ?
                                 txclk_r[0] : txclk_r[1]; // R7
      if (rxind_sel_en) begin
        out_port[BIT_RXRDY_A] <= 1'b0; // R8
        out_port_bit4_oe      <= ~rx_ind_n; // R8
      end
    end
  end
endmodule
`default_nettype wire

//--- test/duart_pins_chk.sv
`timescale 1ns/1ps
`default_nettype none
module duart_pins_chk (
  // clock
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       clk_en,
  // iack
  input wire logic       irq_ack_in_n,
  input wire logic       irq_pending,
  input wire logic [7:0] irq_vector,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       transfer_ack_n,
  // config
  input wire logic [1:0] tx_enable,
  input wire logic [1:0] loopback,
  input wire logic [7:0] out_port_gp,
  input wire logic [1:0] rts_sel,
  input wire logic       txclk_sel_en,
  // pins
  input wire logic       serial_out_ch_a,
  input wire logic       tx_valid_a,
  input wire logic       tx_ready_a,
  input wire logic [7:0] out_port
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n || !clk_en);
  ////////////////////////////////////////////////////////////////////
  ack_on_pend_a: assert property (irq_ack_in_n ##1
    (!irq_ack_in_n && irq_pending)[*5] |-> !transfer_ack_n && data_oe)
    else $error("no acknowledge while pending");
  ack_no_pend_a: assert property ((!irq_pending)[*4]
    |-> transfer_ack_n && !data_oe) else $error("answer without pending");
  ack_release_a: assert property (irq_ack_in_n[*4]
    |-> transfer_ack_n && !data_oe) else $error("answer not released");
  vector_out_a: assert property (!transfer_ack_n && $stable(irq_vector)
    |-> data_out == irq_vector) else $error("wrong vector");
  tx_start_a: assert property (tx_valid_a && tx_ready_a && tx_enable[0]
    && !loopback[0] |-> ##2 !serial_out_ch_a) else $error("no start bit");
  tx_mark_a: assert property ((!tx_enable[0] || loopback[0])[*2]
    |-> serial_out_ch_a) else $error("line not at mark");
  gp_plain_a: assert property ($stable(out_port_gp)
    |-> out_port[3] == ~out_port_gp[3]) else $error("port bit 3 wrong");
  gp_rts_a: assert property ((!rts_sel[0])[*2] ##0 $stable(out_port_gp)
    |-> out_port[0] == ~out_port_gp[0]) else $error("port bit 0 wrong");
  gp_txclk_a: assert property ((!txclk_sel_en)[*2] ##0
    $stable(out_port_gp) |-> out_port[2] == ~out_port_gp[2])
    else $error("port bit 2 wrong");
endmodule
`default_nettype wire

//--- test/uart_remote.sv
`timescale 1ns/1ps
`default_nettype none
module uart_remote #(
  parameter int BIT = 32
) (
  // line
  input  wire logic clk_sys,
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got;
  int         n = 0;
  initial line_out = 1'b1;
  ////////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] b);
    @(negedge clk_sys) line_out = 1'b0;
    repeat (BIT) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      line_out = b[i];
      repeat (BIT) @(negedge clk_sys);
    end
    line_out = 1'b1;
    repeat (BIT) @(negedge clk_sys);
  endtask
  initial forever begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_sys);
      got[i] = line_in;
    end
    repeat (BIT) @(posedge clk_sys);
    n++;
  end
endmodule
`default_nettype wire

//--- test/duart_pins_tb.sv
`timescale 1ns/1ps
`default_nettype none
module duart_pins_tb;
  import duart_pins_pkg::*;
  logic        clk_sys, rst_n, clk_en, irq_ack_in_n, irq_pending;
  logic        data_oe, transfer_ack_n, transfer_ack_oe;
  logic [7:0]  irq_vector, data_out, out_port_gp, out_port;
  logic [15:0] baud_div_a, baud_div_b;
  logic [1:0]  tx_enable, rx_enable, loopback, rts_sel;
  logic [1:0]  rts_auto_rx, rts_auto_tx, rts_assert;
  logic        txclk_sel_en, rxind_sel_en, out_port_bit4_oe;
  txclk_sel_e  txclk_rate;
  rxind_sel_e  rxind_mode;
  logic        serial_in_ch_a, serial_in_ch_b;
  logic        serial_out_ch_a, serial_out_ch_b;
  logic        tx_valid_a, tx_ready_a, rx_valid_a, rx_take_a;
  logic        tx_valid_b, tx_ready_b, rx_valid_b, rx_take_b;
  logic [7:0]  tx_data_a, rx_data_a, tx_data_b, rx_data_b;
  int          fails, cmp_count, cycles;
  duart_pins duart_pins_i (.*);
  uart_remote #(.BIT(32)) uart_remote_i (.clk_sys,
    .line_in(serial_out_ch_a), .line_out(serial_in_ch_a));
  uart_remote #(.BIT(32)) uart_remote_b_i (.clk_sys,
    .line_in(serial_out_ch_b), .line_out(serial_in_ch_b));
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic tx(input logic ch, input logic [7:0] b);
    {tx_data_a, tx_data_b} = {b, b};
    if (ch) tx_valid_b = 1'b1;
    else tx_valid_a = 1'b1;
    while (!(ch ? tx_ready_b : tx_ready_a)) cyc(1);
    cyc(1);
    {tx_valid_a, tx_valid_b} = 2'b00;
    cyc(1);
  endtask
  task automatic take(input logic ch);
    {rx_take_b, rx_take_a} = ch ? 2'b10 : 2'b01;
    cyc(1);
    {rx_take_b, rx_take_a} = 2'b00;
    cyc(2);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({serial_out_ch_a, serial_out_ch_b, transfer_ack_n}, 3'b111);
    chk(out_port, 8'hFF);
    out_port_gp = 8'h3C;
    tx_enable = 2'b01;
    cyc(3);
    chk(out_port, 8'hC3);
    chk(serial_out_ch_b, 1'b1);
    out_port_gp = 8'h00;
    tx_enable = 2'b11;
    cyc(2);
  endtask
  task automatic t_iack();
    irq_vector = 8'h5A;
    irq_pending = 1'b1;
    irq_ack_in_n = 1'b0;
    cyc(5);
    chk({transfer_ack_n, data_oe, data_out}, {2'b01, 8'h5A});
    irq_ack_in_n = 1'b1;
    cyc(5);
    chk({transfer_ack_n, data_oe}, 2'b10);
    irq_pending = 1'b0;
    irq_ack_in_n = 1'b0;
    cyc(6);
    chk({transfer_ack_n, data_oe}, 2'b10);
    irq_ack_in_n = 1'b1;
    cyc(5);
  endtask
  task automatic t_tx();
    tx(0, 8'hA5);
    tx(0, 8'h80);
    cyc(400);
    chk(uart_remote_i.n, 2);
    chk(uart_remote_i.got, 8'h80);
    tx(1, 8'h3C);
    cyc(400);
    chk(uart_remote_b_i.got, 8'h3C);
    uart_remote_b_i.send(8'hC3);
    cyc(40);
    chk({rx_valid_b, rx_data_b}, {1'b1, 8'hC3});
    take(1);
  endtask
  task automatic t_rx();
    logic [7:0] v [4] = '{8'h96, 8'h01, 8'h80, 8'h7E};
    rxind_sel_en = 1'b1;
    rxind_mode = RXIND_FULL;
    {rts_sel, rts_auto_rx, rts_assert} = 6'b01_01_01;
    cyc(1);
    rts_assert = 2'b00;
    cyc(2);
    chk(out_port[0], 1'b0);
    for (int i = 0; i < 4; i++) begin
      uart_remote_i.send(v[i]);
      cyc(40);
      chk({out_port_bit4_oe, out_port[0]}, {2{i == 3}});
    end
    rxind_mode = RXIND_READY;
    for (int i = 0; i < 4; i++) begin
      cyc(2);
      chk({out_port_bit4_oe, rx_valid_a, rx_data_a}, {2'b11, v[i]});
      take(0);
    end
    chk({out_port_bit4_oe, rx_valid_a}, 2'b00);
    {rxind_sel_en, rts_sel, rts_auto_rx} = 5'b0;
  endtask
  task automatic t_loop();
    loopback = 2'b01;
    tx(0, 8'h6B);
    cyc(400);
    chk(uart_remote_i.n, 2);
    chk({rx_valid_a, rx_data_a}, {1'b1, 8'h6B});
    take(0);
    loopback = 2'b00;
  endtask
  task automatic t_rts();
    {rts_sel, rts_auto_tx, rts_assert} = 6'b11_01_11;
    cyc(1);
    rts_assert = 2'b00;
    cyc(2);
    chk(out_port[1:0], 2'b00);
    tx(0, 8'hFF);
    cyc(400);
    chk(out_port[1:0], 2'b01);
    {rts_sel, rts_auto_tx} = 4'b0;
    cyc(2);
    chk(out_port[1:0], 2'b11);
  endtask
  task automatic t_txclk();
    int   c [2];
    logic p;
    txclk_sel_en = 1'b1;
    for (int r = 0; r < 2; r++) begin
      txclk_rate = r ? TXCLK_16X : TXCLK_1X;
      c[r] = 0;
      cyc(2);
      p = out_port[2];
      repeat (320) begin
        cyc(1);
        if (out_port[2] !== p) c[r]++;
        p = out_port[2];
      end
    end
    chk(c[1] > c[0] && c[0] > 0, 1'b1);
    chk(c[0] inside {[19:21]}, 1'b1);
    chk(c[1] inside {[318:320]}, 1'b1);
    txclk_sel_en = 1'b0;
    cyc(2);
  endtask
  task automatic t_freeze();
    clk_en = 1'b0;
    out_port_gp = 8'hF0;
    cyc(4);
    chk(out_port, 8'hFF);
    clk_en = 1'b1;
    cyc(2);
    chk(out_port, 8'h0F);
    out_port_gp = 8'h00;
    cyc(2);
  endtask
  ////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    {clk_sys, rst_n, clk_en, irq_ack_in_n, irq_pending} = 5'b00110;
    {irq_vector, out_port_gp, loopback, rts_sel} = '0;
    {rts_auto_rx, rts_auto_tx, rts_assert} = '0;
    {baud_div_a, baud_div_b} = {16'h0002, 16'h0002};
    {tx_enable, rx_enable} = 4'b1111;
    {txclk_sel_en, rxind_sel_en} = 2'b00;
    txclk_rate = TXCLK_1X;
    rxind_mode = RXIND_READY;
    {tx_valid_a, tx_data_a, rx_take_a} = '0;
    {tx_valid_b, tx_data_b, rx_take_b} = '0;
    {fails, cmp_count, cycles} = '0;
    cyc(16);
    rst_n = 1'b1;
    cyc(1);
    t_reset();
    t_iack();
    t_tx();
    t_rx();
    t_loop();
    t_rts();
    t_txclk();
    t_freeze();
    test_done();
  end
endmodule
bind duart_pins duart_pins_chk duart_pins_chk_i (.clk_sys, .rst_n, .clk_en,
  .irq_ack_in_n, .irq_pending, .irq_vector, .data_out, .data_oe,
  .transfer_ack_n, .tx_enable, .loopback, .out_port_gp, .rts_sel,
  .txclk_sel_en, .serial_out_ch_a, .tx_valid_a, .tx_ready_a, .out_port);
`default_nettype wire
